// File: sim/aau_mem_model.sv
// Far-side data memory model watching the second address bus
`default_nettype none
module aau_mem_model #(
   parameter aau_pkg::aau_word_type ONCHIP_TOP = 16'h07FF
) (
   input  wire logic                  i_clock,
   input  wire logic                  i_reset_n,
   input  wire logic                  i_addr2_valid,
   input  wire aau_pkg::aau_word_type i_addr2,
   output var  aau_pkg::aau_word_type o_last_addr2,
   output var  logic                  o_offchip
);
   timeunit 1ns;
   timeprecision 1ps;
   import aau_pkg::*;
   always @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_last_addr2 <= AAU_ZERO;
         o_offchip <= 1'b0;
      end else if (i_addr2_valid) begin
         o_last_addr2 <= i_addr2;
         o_offchip <= o_offchip | (i_addr2 > ONCHIP_TOP);
      end
   end
endmodule
`default_nettype wire

// File: sim/aau_monitor.sv
// Port checker of the address update unit
`default_nettype none
module aau_monitor (
   input wire logic                   i_clock,
   input wire logic                   i_reset_n,
   input wire aau_pkg::aau_req_type   i_req,
   input wire aau_pkg::aau_bus_type   i_bus,
   input wire logic                   o_stall,
   input wire aau_pkg::aau_word_type  o_bus_rdata,
   input wire logic                   o_addr1_valid,
   input wire aau_pkg::aau_word_type  o_addr1,
   input wire logic                   o_addr2_valid,
   input wire aau_pkg::aau_word_type  o_addr2,
   input wire aau_pkg::aau_word_type  o_operand,
   input wire aau_pkg::aau_class_type o_operand_class,
   input wire logic                   o_wrap
);
   timeunit 1ns;
   timeprecision 1ps;
   import aau_pkg::*;
   logic take;
   assign take = i_req.valid && !o_stall;
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_reset_n);
   a_stall_single: assert property (o_stall |=> !o_stall)
      else $error("stall longer than one cycle");
   a_stall_cause: assert property (o_stall |-> $past(i_bus.wr && !i_bus.bitfield
      && i_bus.sel == AAU_REG_OFFSET && i_req.next_uses_offset))
      else $error("stall without offset move");
   a_addr_cause: assert property (o_addr1_valid |-> $past(take
      && i_req.ea.mode inside {AAU_MODE_INDIRECT, AAU_MODE_ABSOLUTE}))
      else $error("address pulse without request");
   a_abs_answer: assert property (take && i_req.ea.mode == AAU_MODE_ABSOLUTE
      |=> o_addr1_valid && o_addr1 == $past(i_req.ea.value))
      else $error("absolute address wrong");
   a_dual_answer: assert property (take && i_req.dual_read |=> o_addr2_valid)
      else $error("second address missing");
   a_wrap_owner: assert property (o_wrap |-> $past(take && i_req.ea.mode ==
      AAU_MODE_INDIRECT && (i_req.ea.areg == AAU_REG_P0 ||
      (i_req.ea.areg == AAU_REG_P1 && i_req.ea.use_modifier))))
      else $error("wrap on a linear pointer");
   a_class_cause: assert property (o_operand_class != AAU_CLASS_NONE |->
      $past(take && i_req.ea.mode == AAU_MODE_REG_DIRECT))
      else $error("operand class without register access");
   a_imm_value: assert property (take && i_req.ea.mode == AAU_MODE_IMMEDIATE
      |=> o_operand == $past(i_req.ea.value) && o_operand_class == AAU_CLASS_NONE)
      else $error("immediate operand wrong");
   a_rdata_hold: assert property (!$past(i_bus.rd) |-> $stable(o_bus_rdata))
      else $error("read data changed without read");
   c_stall: cover property (o_stall);
   c_wrap: cover property (o_wrap);
   c_dual: cover property (o_addr2_valid);
endmodule
bind aau_address_update_unit aau_monitor u_mon (.i_clock, .i_reset_n, .i_req, .i_bus,
   .o_stall, .o_bus_rdata, .o_addr1_valid, .o_addr1, .o_addr2_valid, .o_addr2, .o_operand,
   .o_operand_class, .o_wrap);
`default_nettype wire

// File: sim/tb_top.sv
// Self-checking bench of the address update unit
`default_nettype none
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import aau_pkg::*;
   logic          i_clock = 1'b0;
   logic          i_reset_n = 1'b0;
   aau_req_type   i_req = '0;
   aau_bus_type   i_bus = '0;
   logic          o_stall, o_addr1_valid, o_addr2_valid, o_wrap, offchip;
   aau_word_type  o_bus_rdata, o_addr1, o_addr2, o_operand, last2, d;
   aau_class_type o_operand_class;
   int            error_cnt = 0;
   int            checks_done = 0;
   aau_areg_type  ar [6] = '{AAU_REG_P0, AAU_REG_P1, AAU_REG_P1, AAU_REG_P2, AAU_REG_P3,
                             AAU_REG_STACK};
   logic          um [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   aau_word_type  num [4] = '{16'h0000, 16'h0009, 16'h0010, 16'h0014};
   aau_class_type cls [4] = '{AAU_CLASS_DATA, AAU_CLASS_ADDR, AAU_CLASS_CTRL, AAU_CLASS_NONE};
   always #2 i_clock = ~i_clock;
   aau_address_update_unit u_dut (.i_clock, .i_reset_n, .i_req, .i_bus, .o_stall,
      .o_bus_rdata, .o_addr1_valid, .o_addr1, .o_addr2_valid, .o_addr2, .o_operand,
      .o_operand_class, .o_wrap);
   aau_mem_model u_mem (.i_clock, .i_reset_n, .i_addr2_valid(o_addr2_valid),
      .i_addr2(o_addr2), .o_last_addr2(last2), .o_offchip(offchip));
   task automatic complete_run();
      $display("Checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic bus_wr(input aau_areg_type s, input aau_word_type v, input logic bf,
                         input logic nuo);
      @(negedge i_clock);
      i_bus = '{wr: 1'b1, bitfield: bf, rd: 1'b0, sel: s, wdata: v};
      i_req.next_uses_offset = nuo;
      @(negedge i_clock);
      i_bus.wr = 1'b0;
      i_req.next_uses_offset = 1'b0;
   endtask
   task automatic bus_rd(input aau_areg_type s, input aau_word_type exp);
      @(negedge i_clock);
      i_bus.rd = 1'b1;
      i_bus.sel = s;
      @(negedge i_clock);
      i_bus.rd = 1'b0;
      check("rdata", o_bus_rdata, exp);
   endtask
   task automatic op(input aau_mode_type m, input aau_areg_type a, input aau_update_type u,
                     input logic [2:0] f, input aau_word_type v);
      @(negedge i_clock);
      i_req.valid = 1'b1;
      i_req.ea = '{mode: m, areg: a, update: u, use_modifier: f[0], reg_num: v[4:0], value: v};
      i_req.dual_read = f[1];
      i_req.fourth_dec = f[2];
      @(negedge i_clock);
      i_req.valid = 1'b0;
   endtask
   task automatic set_reg(input aau_areg_type a, input aau_word_type v);
      bus_wr(a, v, 1'b0, 1'b0);
      op(AAU_MODE_REG_DIRECT, AAU_REG_P0, AAU_UPD_NONE, 3'h0, 16'h0014);
   endtask
   task automatic t_offset();
      bus_rd(AAU_REG_MODIFIER, AAU_MOD_RESET);
      set_reg(AAU_REG_P2, 16'h0100);
      bus_wr(AAU_REG_OFFSET, 16'h0030, 1'b0, 1'b1);
      check("stall", {15'h0, o_stall}, 16'h0001);
      i_req.ea = '{mode: AAU_MODE_INDIRECT, areg: AAU_REG_P2, update: AAU_UPD_POST_OFFSET,
                   use_modifier: 1'b0, reg_num: 5'h00, value: AAU_ZERO};
      i_req.valid = 1'b1;
      @(negedge i_clock);
      check("addr1_valid", {15'h0, o_addr1_valid}, 16'h0000);
      @(negedge i_clock);
      i_req.valid = 1'b0;
      check("addr1_valid", {15'h0, o_addr1_valid}, 16'h0001);
      check("addr1", o_addr1, 16'h0100);
      bus_rd(AAU_REG_P2, 16'h0130);
      bus_wr(AAU_REG_OFFSET, 16'h0010, 1'b0, 1'b0);
      check("stall", {15'h0, o_stall}, 16'h0000);
      bus_wr(AAU_REG_OFFSET, 16'h0050, 1'b1, 1'b1);
      check("stall", {15'h0, o_stall}, 16'h0000);
      bus_rd(AAU_REG_OFFSET, 16'h0010);
      bus_wr(AAU_REG_P1, 16'h0200, 1'b0, 1'b0);
      bus_rd(AAU_REG_P1, AAU_PTR_RESET);
      op(AAU_MODE_REG_DIRECT, AAU_REG_P0, AAU_UPD_NONE, 3'h0, 16'h0014);
      bus_rd(AAU_REG_P1, 16'h0200);
      bus_rd(AAU_REG_OFFSET, 16'h0050);
   endtask
   task automatic t_reset_linear();
      @(negedge i_clock);
      i_reset_n = 1'b0;
      repeat (3) @(negedge i_clock);
      i_reset_n = 1'b1;
      bus_rd(AAU_REG_MODIFIER, AAU_MOD_RESET);
      set_reg(AAU_REG_P0, 16'h0007);
      op(AAU_MODE_INDIRECT, AAU_REG_P0, AAU_UPD_POST_INC, 3'h0, 16'h0000);
      check("wrap", {15'h0, o_wrap}, 16'h0000);
      bus_rd(AAU_REG_P0, 16'h0008);
   endtask
   task automatic t_modulo();
      set_reg(AAU_REG_MODIFIER, 16'h0007);
      for (int i = 0; i < 6; i++) begin
         set_reg(ar[i], 16'h0007);
         op(AAU_MODE_INDIRECT, ar[i], AAU_UPD_POST_INC, {2'b00, um[i]}, 16'h0000);
         check("addr1", o_addr1, 16'h0007);
         check("wrap", {15'h0, o_wrap}, (i < 2) ? 16'h0001 : 16'h0000);
         bus_rd(ar[i], (i < 2) ? 16'h0000 : 16'h0008);
      end
      set_reg(AAU_REG_P0, 16'h0000);
      op(AAU_MODE_INDIRECT, AAU_REG_P0, AAU_UPD_POST_DEC, 3'h0, 16'h0000);
      bus_rd(AAU_REG_P0, 16'h0007);
      set_reg(AAU_REG_P3, 16'h0005);
      op(AAU_MODE_INDIRECT, AAU_REG_P0, AAU_UPD_NONE, 3'b110, 16'h0000);
      check("addr2_valid", {15'h0, o_addr2_valid}, 16'h0001);
      check("addr2", o_addr2, 16'h0005);
      bus_rd(AAU_REG_P3, 16'h0004);
      check("mem2", last2, 16'h0005);
      op(AAU_MODE_INDIRECT, AAU_REG_P0, AAU_UPD_NONE, 3'b010, 16'h0000);
      check("addr2", o_addr2, 16'h0004);
      bus_rd(AAU_REG_P3, 16'h0005);
   endtask
   task automatic t_modes();
      for (int i = 0; i < 4; i++) begin
         op(AAU_MODE_REG_DIRECT, AAU_REG_MODIFIER, AAU_UPD_NONE, 3'h0, num[i]);
         check("class", {14'h0, o_operand_class}, {14'h0, cls[i]});
         if (i == 1) check("operand", o_operand, 16'h0007);
      end
      op(AAU_MODE_IMMEDIATE, AAU_REG_P0, AAU_UPD_NONE, 3'h0, 16'hA5C3);
      check("operand", o_operand, 16'hA5C3);
      op(AAU_MODE_ABSOLUTE, AAU_REG_P0, AAU_UPD_NONE, 3'h0, 16'h1234);
      check("addr1", o_addr1, 16'h1234);
      check("offchip", {15'h0, offchip}, 16'h0000);
   endtask
   initial begin
      repeat (6) @(negedge i_clock);
      i_reset_n = 1'b1;
      t_offset();
      t_reset_linear();
      t_modulo();
      t_modes();
      complete_run();
   end
   initial begin
      #20000;
      error_cnt++;
      complete_run();
   end
endmodule
`default_nettype wire

// File: verilog/aau_address_update_unit.sv
// Address update datapath: offset, modifier, pointers, modulo and linear units
`default_nettype none
// What this block does
// RULE1 - One offset register serves all pointers
// RULE2 - Offset move used next: stretch one cycle
// RULE3 - Bit-field offset write visible two instructions later
// RULE4 - Modifier always for first, optional second
// RULE5 - Modifier ignored for third, fourth, stack
// RULE6 - Reset loads modifier with all ones
// RULE7 - Pointer or modifier writes visible two later
// RULE8 - Software avoids stack use right after change
// RULE9 - Modulo unit updates one pointer per cycle
// RULE10 - Modulo wrap only on first, second pointer
// RULE11 - Linear result always computed, used when linear
// RULE12 - Modulo adder sum chosen only on wraparound
// RULE13 - Dual read steps fourth pointer linearly
// RULE14 - Register direct selects data, address, control
// RULE15 - Four addressing mode categories supported
// RULE16 - Indirect decode: pointer, calculation, update
// RULE17 - Four 16-bit pointers, bus and unit access
// RULE18 - Second dual read always on-chip memory
// RULE19 - Non-linear modifier means modulo; wrap exposed
module aau_address_update_unit (
   input  wire logic                  i_clock,
   input  wire logic                  i_reset_n,
   input  wire aau_pkg::aau_req_type  i_req,
   input  wire aau_pkg::aau_bus_type  i_bus,
   output logic                       o_stall,
   output aau_pkg::aau_word_type      o_bus_rdata,
   output logic                       o_addr1_valid,
   output aau_pkg::aau_word_type      o_addr1,
   output logic                       o_addr2_valid,
   output aau_pkg::aau_word_type      o_addr2,
   output aau_pkg::aau_word_type      o_operand,
   output aau_pkg::aau_class_type     o_operand_class,
   output logic                       o_wrap
);
   import aau_pkg::*;

   // ****************************************
   // Functions
   // ****************************************
   function automatic aau_word_type fill_mask(input aau_word_type m);
      aau_word_type f;
      f = m;
      f = f | (f >> 1);
      f = f | (f >> 2);
      f = f | (f >> 4);
      f = f | (f >> 8);
      return f;
   endfunction

   // Returns {wrap, result}
   function automatic logic [AAU_W:0] modulo_step(input aau_word_type cur,
                                                  input aau_word_type step,
                                                  input aau_word_type m);
      aau_word_type     mask;
      aau_word_type     lin;
      logic [AAU_W:0]   modulus;
      logic [AAU_W:0]   pos;
      logic             wrap;
      aau_word_type     res;
      mask    = fill_mask(m);
      lin     = cur + step;                                   // RULE11
      modulus = {1'b0, m} + {1'b0, AAU_ONE};
      pos     = {1'b0, cur & mask} + {step[AAU_W-1], step};
      wrap    = 1'b0;
      res     = lin;
      if (step[AAU_W-1] && pos[AAU_W]) begin
         wrap = 1'b1;
         res  = lin + modulus[AAU_W-1:0];                     // RULE12
      end else if (!step[AAU_W-1] && (pos > {1'b0, m})) begin
         wrap = 1'b1;
         res  = lin - modulus[AAU_W-1:0];                     // RULE12
      end
      return {wrap, res};
   endfunction

   function automatic aau_class_type rd_class(input logic [4:0] num);
      if (num < AAU_RD_ADDR_BASE) begin
         rd_class = AAU_CLASS_DATA;                           // RULE14
      end else if (num < AAU_RD_CTRL_BASE) begin
         rd_class = AAU_CLASS_ADDR;
      end else if (num < AAU_RD_LIMIT) begin
         rd_class = AAU_CLASS_CTRL;
      end else begin
         rd_class = AAU_CLASS_NONE;
      end
   endfunction

   // ****************************************
   // State
   // ****************************************
   aau_word_type ptr_r [AAU_PTR_COUNT];
   aau_word_type stack_r;
   aau_word_type offset_r;
   aau_word_type modifier_r;
   logic         stall_r;
   logic         pend_valid_r;
   aau_areg_type pend_sel_r;
   aau_word_type pend_data_r;

   function automatic aau_word_type read_areg(input aau_areg_type sel);
      unique case (sel)
         AAU_REG_P0:       read_areg = ptr_r[0];
         AAU_REG_P1:       read_areg = ptr_r[1];
         AAU_REG_P2:       read_areg = ptr_r[2];
         AAU_REG_P3:       read_areg = ptr_r[3];
         AAU_REG_OFFSET:   read_areg = offset_r;
         AAU_REG_MODIFIER: read_areg = modifier_r;
         AAU_REG_STACK:    read_areg = stack_r;
         default:          read_areg = AAU_ZERO;
      endcase
   endfunction

   // ****************************************
   // Instruction cycle and write staging
   // ****************************************
   logic         tick;
   logic         accept;
   logic         bus_wr;
   logic         ofs_direct;
   logic         commit;

   assign accept     = i_req.valid && !stall_r;
   assign bus_wr     = i_bus.wr && !stall_r;
   assign tick       = accept || bus_wr;
   assign ofs_direct = bus_wr && !i_bus.bitfield && (i_bus.sel == AAU_REG_OFFSET);
   assign commit     = tick && pend_valid_r;

   // Writes other than an offset move wait one instruction before landing
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         pend_valid_r <= 1'b0;
         pend_sel_r   <= AAU_REG_P0;
         pend_data_r  <= AAU_ZERO;
      end else if (bus_wr && !ofs_direct) begin
         pend_valid_r <= 1'b1;                                // RULE3 RULE7
         pend_sel_r   <= i_bus.sel;
         pend_data_r  <= i_bus.wdata;
      end else if (tick) begin
         pend_valid_r <= 1'b0;
      end
   end

   // Stretch the offset move when the next instruction needs it
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         stall_r <= 1'b0;
      end else begin
         stall_r <= ofs_direct && i_req.next_uses_offset;     // RULE2
      end
   end

   // ****************************************
   // Address calculation
   // ****************************************
   aau_word_type cur;
   aau_word_type step;
   aau_word_type upd;
   aau_word_type addr1;
   logic         mod_active;
   logic         upd_wrap;
   logic         upd_en;
   logic         indirect;
   logic         dual;
   logic [AAU_W:0] mod_res;

   always_comb begin
      indirect   = accept && (i_req.ea.mode == AAU_MODE_INDIRECT);
      dual       = indirect && i_req.dual_read;
      cur        = read_areg(i_req.ea.areg);
      step       = AAU_ZERO;
      upd_en     = 1'b0;
      addr1      = cur;
      unique case (i_req.ea.update)                           // RULE16
         AAU_UPD_NONE: begin
            upd_en = 1'b0;
         end
         AAU_UPD_POST_INC: begin
            step   = AAU_ONE;
            upd_en = indirect;
         end
         AAU_UPD_POST_DEC: begin
            step   = AAU_MINUS_ONE;
            upd_en = indirect;
         end
         AAU_UPD_POST_OFFSET: begin
            step   = offset_r;                                // RULE1
            upd_en = indirect;
         end
         AAU_UPD_INDEX_OFFSET: begin
            addr1  = cur + offset_r;                          // RULE1
         end
         AAU_UPD_INDEX_DISP: begin
            addr1  = cur + i_req.ea.value;
         end
         default: begin
            upd_en = 1'b0;
         end
      endcase
      mod_active = (modifier_r != AAU_LINEAR) &&              // RULE19
                   ((i_req.ea.areg == AAU_REG_P0) ||          // RULE4 RULE10
                    ((i_req.ea.areg == AAU_REG_P1) && i_req.ea.use_modifier)); // RULE5
      mod_res    = modulo_step(cur, step, modifier_r);
      upd        = mod_active ? mod_res[AAU_W-1:0] : cur + step; // RULE11 RULE12
      upd_wrap   = upd_en && mod_active && mod_res[AAU_W];
   end

   // ****************************************
   // Register file
   // ****************************************
   // Single update port for the addressed pointer or stack; dual read and a write commit can change others in the same cycle
   generate
      for (genvar k = 0; k < AAU_PTR_COUNT; k++) begin : g_ptr
         always_ff @(posedge i_clock) begin
            if (!i_reset_n) begin
               ptr_r[k] <= AAU_PTR_RESET;
            end else if (commit && (pend_sel_r == aau_areg_type'(k))) begin
               ptr_r[k] <= pend_data_r;                       // RULE7 RULE17
            end else if ((k == AAU_PTR_COUNT - 1) && dual) begin
               if (i_req.fourth_dec) begin
                  ptr_r[k] <= ptr_r[k] - AAU_ONE;             // RULE13
               end else begin
                  ptr_r[k] <= ptr_r[k] + AAU_ONE;             // RULE13
               end
            end else if (upd_en && (i_req.ea.areg == aau_areg_type'(k))) begin
               ptr_r[k] <= upd;                               // RULE9 RULE17
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         stack_r <= AAU_PTR_RESET;
      end else if (commit && (pend_sel_r == AAU_REG_STACK)) begin
         stack_r <= pend_data_r;                              // RULE7
      end else if (upd_en && (i_req.ea.areg == AAU_REG_STACK)) begin
         stack_r <= upd;                                      // RULE9 RULE10
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         offset_r <= AAU_OFS_RESET;
      end else if (ofs_direct) begin
         offset_r <= i_bus.wdata;                             // RULE2
      end else if (commit && (pend_sel_r == AAU_REG_OFFSET)) begin
         offset_r <= pend_data_r;                             // RULE3
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         modifier_r <= AAU_MOD_RESET;                         // RULE6
      end else if (commit && (pend_sel_r == AAU_REG_MODIFIER)) begin
         modifier_r <= pend_data_r;                           // RULE7
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_bus_rdata <= AAU_ZERO;
      end else if (i_bus.rd) begin
         o_bus_rdata <= read_areg(i_bus.sel);
      end
   end

   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_addr1_valid   <= 1'b0;
         o_addr1         <= AAU_ZERO;
         o_addr2_valid   <= 1'b0;
         o_addr2         <= AAU_ZERO;
         o_operand       <= AAU_ZERO;
         o_operand_class <= AAU_CLASS_NONE;
         o_wrap          <= 1'b0;
      end else begin
         o_addr1_valid   <= 1'b0;
         o_addr2_valid   <= dual;                             // RULE18
         o_addr2         <= ptr_r[AAU_PTR_COUNT-1];
         o_wrap          <= upd_wrap;                         // RULE19
         o_operand_class <= AAU_CLASS_NONE;
         if (accept) begin
            unique case (i_req.ea.mode)                       // RULE15
               AAU_MODE_REG_DIRECT: begin
                  o_operand_class <= rd_class(i_req.ea.reg_num); // RULE14
                  o_operand       <= read_areg(i_req.ea.areg);
               end
               AAU_MODE_INDIRECT: begin
                  o_addr1_valid <= 1'b1;                      // RULE16
                  o_addr1       <= addr1;
               end
               AAU_MODE_IMMEDIATE: begin
                  o_operand     <= i_req.ea.value;
               end
               AAU_MODE_ABSOLUTE: begin
                  o_addr1_valid <= 1'b1;
                  o_addr1       <= i_req.ea.value;
               end
            endcase
         end
      end
   end

   assign o_stall = stall_r;
endmodule
`default_nettype wire

// File: verilog/aau_pkg.sv
// Constants, enumerations and carrier types of the address update unit
`default_nettype none
package aau_pkg;
   localparam int unsigned AAU_W           = 16;
   typedef logic [AAU_W-1:0] aau_word_type;
   localparam aau_word_type AAU_ZERO       = 16'h0000;
   localparam aau_word_type AAU_ONE        = 16'h0001;
   localparam aau_word_type AAU_MINUS_ONE  = 16'hFFFF;
   localparam aau_word_type AAU_LINEAR     = 16'hFFFF;
   localparam aau_word_type AAU_MOD_RESET  = 16'hFFFF;
   localparam aau_word_type AAU_PTR_RESET  = 16'h0000;
   localparam aau_word_type AAU_OFS_RESET  = 16'h0000;
   localparam int unsigned AAU_PTR_COUNT   = 4;
   // Register-direct numbering: data, then address, then control
   localparam int unsigned AAU_DATA_COUNT  = 9;
   localparam int unsigned AAU_ADDR_COUNT  = 7;
   localparam int unsigned AAU_CTRL_COUNT  = 4;
   localparam logic [4:0]  AAU_RD_ADDR_BASE = 5'h09;
   localparam logic [4:0]  AAU_RD_CTRL_BASE = 5'h10;
   localparam logic [4:0]  AAU_RD_LIMIT     = 5'h14;

   typedef enum logic [2:0] {
      AAU_REG_P0, AAU_REG_P1, AAU_REG_P2, AAU_REG_P3,
      AAU_REG_OFFSET, AAU_REG_MODIFIER, AAU_REG_STACK
   } aau_areg_type;

   typedef enum logic [1:0] {
      AAU_MODE_REG_DIRECT, AAU_MODE_INDIRECT, AAU_MODE_IMMEDIATE, AAU_MODE_ABSOLUTE
   } aau_mode_type;

   typedef enum logic [2:0] {
      AAU_UPD_NONE, AAU_UPD_POST_INC, AAU_UPD_POST_DEC, AAU_UPD_POST_OFFSET,
      AAU_UPD_INDEX_OFFSET, AAU_UPD_INDEX_DISP
   } aau_update_type;

   typedef enum logic [1:0] {
      AAU_CLASS_DATA, AAU_CLASS_ADDR, AAU_CLASS_CTRL, AAU_CLASS_NONE
   } aau_class_type;

   typedef struct packed {
      aau_mode_type   mode;
      aau_areg_type   areg;
      aau_update_type update;
      logic           use_modifier;
      logic [4:0]     reg_num;
      aau_word_type   value;
   } aau_ea_type;

   typedef struct packed {
      logic       valid;
      aau_ea_type ea;
      logic       dual_read;
      logic       fourth_dec;
      logic       next_uses_offset;
   } aau_req_type;

   typedef struct packed {
      logic         wr;
      logic         bitfield;
      logic         rd;
      aau_areg_type sel;
      aau_word_type wdata;
   } aau_bus_type;
endpackage
`default_nettype wire
